// file: rtl/rtc_core.sv
// Real-time clock core: BCD calendar, two alarms, shared interrupt/square-wave
// pin, reference clock output, power-up reset recovery and oscillator-stop flag.
// Assumes osc_clk_i runs at twice the reference rate and that the supply
// comparator drives power_ok_i; analog switching and pushbutton live outside.
//
// Function
// - Hold reset low 125 ms after power.
// - Oscillator disabled: release reset at once.
// - Flag oscillator stop after detection period.
// - Stop detection period is 100 ms.
// - Serial port abandons stalled transactions.
// - Reference output carries half the oscillator frequency.
// - Either reference enable low: output low.
// - Control register bit selects pin function.
// - Mode zero: square wave at selected rate.
// - Mode one: pin asserts on alarm match.
// - Reset: interrupt mode, both alarms disabled.
// - Pin is active-low open drain.
// - Separate seconds through year counts.
// - Month end and leap year rollover.
// - 12 or 24 hour, AM/PM kept.
// - Two independent alarms plus square wave.
// - Registers reached only over serial bus.
// - Reset low below threshold, released after delay.
`timescale 1ns/10ps
module rtc_core #(
  parameter int REC_CYC = rtc_pkg::RECOVERY_CYC,
  parameter int OSF_CYC = rtc_pkg::OSC_STOP_CYC,
  parameter int TO_CYC = rtc_pkg::TIMEOUT_CYC,
  parameter logic [6:0] DEV_ADDR = 7'h42
) (
  // Clocks and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic osc_clk_i,
  // Supply comparator, high while above the power-fail threshold
  input wire logic power_ok_i,
  // Serial bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Interrupt or square-wave pin
  input wire logic alarm_irq_sqwave_n_i,
  output logic alarm_irq_sqwave_n_o,
  output logic alarm_irq_sqwave_n_oe_o,
  // Reset pin
  input wire logic reset_n_i,
  output logic reset_n_o,
  output logic reset_n_oe_o,
  // Reference clock
  output logic ref_clock_out_o
);
  localparam int RW = $clog2(REC_CYC + 1);
  localparam int OW = $clog2(OSF_CYC + 1);
  localparam int DW = rtc_pkg::DIV_W;

  logic [1:0] rst_q, osc_rst_q;
  logic rst_n, osc_rst_n;
  logic [7:0] regs [16];
  logic [7:0] next_regs [16];
  logic wr, rst_act, next_rst_act, osf_set, next_osf_set, chk;
  logic [3:0] wr_addr, ptr;
  logic [7:0] wdata;
  logic [RW-1:0] rec_cnt, next_rec_cnt;
  logic [OW-1:0] osf_cnt, next_osf_cnt;
  logic sec_m, sec_s, sec_d, hb_m, hb_s, hb_d, sqw_m, sqw_s, pwr_m, pwr_s;
  logic ref_gate, next_ref_gate, next_int_oe, pin_low;
  logic [DW-1:0] div;
  logic sec_tgl, sqw, ref_q, gate_m, gate_s;
  logic [1:0] rate_m, rate_s;

  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] top);
    if (v == top) return 9'h100;
    if (v[3:0] == 4'h9) return {1'b0, v[7:4] + 4'h1, 4'h0};
    return {1'b0, v + 8'h01};
  endfunction : bcd_inc

  function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) :
                  (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m[4:0])
      5'h02: return leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction : month_last

  function automatic logic fmatch(input logic [7:0] a, input logic [7:0] t);
    return a[rtc_pkg::ALARM_MASK] | (a[6:0] == t[6:0]);
  endfunction : fmatch

  function automatic logic day_match(input logic [7:0] a, input logic [7:0] wd, input logic [7:0] dt);
    if (a[rtc_pkg::ALARM_MASK]) return 1'b1;
    if (a[rtc_pkg::ALARM_BY_WDAY]) return a[3:0] == wd[3:0];
    return a[5:0] == dt[5:0];
  endfunction : day_match

  // Reset release and supply level, each through two flip-flops.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  always_ff @(posedge osc_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      osc_rst_q <= 2'b00;
    end else begin
      osc_rst_q <= {osc_rst_q[0], 1'b1};
    end
  end
  assign osc_rst_n = osc_rst_q[1];

  // Oscillator domain: divider, second toggle, square wave and reference output.
  // The rate bits are quasi-static, so a two-bit level synchroniser is enough.
  always_ff @(posedge osc_clk_i or negedge osc_rst_n) begin
    if (!osc_rst_n) begin
      div <= '0;
      sec_tgl <= 1'b0;
      sqw <= 1'b0;
      ref_q <= 1'b0;
      rate_m <= 2'b11;
      rate_s <= 2'b11;
      gate_m <= 1'b0;
      gate_s <= 1'b0;
    end else begin
      div <= div + DW'(1);
      sec_tgl <= sec_tgl ^ (&div);
      rate_m <= {regs[rtc_pkg::DEVICE_CONTROL_ADDR][rtc_pkg::CTL_RATE_SELECT_HI],
                 regs[rtc_pkg::DEVICE_CONTROL_ADDR][rtc_pkg::CTL_RATE_SELECT_LO]};
      rate_s <= rate_m;
      gate_m <= ref_gate;
      gate_s <= gate_m;
      case (rate_s)
        2'b00: sqw <= div[DW-1];
        2'b01: sqw <= div[rtc_pkg::TAP_1K];
        2'b10: sqw <= div[rtc_pkg::TAP_4K];
        default: sqw <= div[rtc_pkg::TAP_8K];
      endcase
      ref_q <= gate_s & ~ref_q;
    end
  end
  assign ref_clock_out_o = ref_q;

  // Crossings into the system domain.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      {sec_m, sec_s, sec_d, hb_m, hb_s, hb_d} <= 6'h00;
      {sqw_m, sqw_s, pwr_m, pwr_s} <= 4'h0;
    end else begin
      {sec_m, sec_s, sec_d} <= {sec_tgl, sec_m, sec_s};
      {hb_m, hb_s, hb_d} <= {div[rtc_pkg::TAP_HEART], hb_m, hb_s};
      {sqw_m, sqw_s} <= {sqw, sqw_m};
      {pwr_m, pwr_s} <= {power_ok_i, pwr_m};
    end
  end

  i2c_target #(
    .DEV_ADDR(DEV_ADDR),
    .TO_CYC(TO_CYC)
  ) u_port (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_oe_o(sda_oe_o),
    .wr_o(wr),
    .wr_addr_o(wr_addr),
    .wdata_o(wdata),
    .ptr_o(ptr),
    .rdata_i(regs[ptr])
  );

  // Calendar, alarms and register writes.
  always_comb begin
    logic c;
    logic [8:0] t;
    logic [7:0] h;
    c = sec_s ^ sec_d;
    t = 9'h000;
    h = regs[rtc_pkg::HOUR_ADDR];
    next_regs = regs;
    if (c) begin
      t = bcd_inc(regs[rtc_pkg::SEC_ADDR], rtc_pkg::BCD_59);
      next_regs[rtc_pkg::SEC_ADDR] = t[7:0];
      c = t[8];
    end
    if (c) begin
      t = bcd_inc(regs[rtc_pkg::MIN_ADDR], rtc_pkg::BCD_59);
      next_regs[rtc_pkg::MIN_ADDR] = t[7:0];
      c = t[8];
    end
    if (c) begin
      c = 1'b0;
      if (h[rtc_pkg::HOUR_12H]) begin
        if (h[4:0] == 5'h12) begin
          next_regs[rtc_pkg::HOUR_ADDR] = {h[7:5], 5'h01};
        end else if (h[4:0] == 5'h11) begin
          next_regs[rtc_pkg::HOUR_ADDR] = {h[7:6], ~h[rtc_pkg::HOUR_PM], 5'h12};
          c = h[rtc_pkg::HOUR_PM];
        end else begin
          t = bcd_inc({3'b000, h[4:0]}, 8'h12);
          next_regs[rtc_pkg::HOUR_ADDR] = {h[7:5], t[4:0]};
        end
      end else begin
        t = bcd_inc({2'b00, h[5:0]}, rtc_pkg::BCD_23);
        next_regs[rtc_pkg::HOUR_ADDR] = {h[7:6], t[5:0]};
        c = t[8];
      end
    end
    if (c) begin
      next_regs[rtc_pkg::WDAY_ADDR] = (regs[rtc_pkg::WDAY_ADDR][2:0] == 3'h7) ? rtc_pkg::CAL_ONE :
                                      regs[rtc_pkg::WDAY_ADDR] + rtc_pkg::CAL_ONE;
      c = regs[rtc_pkg::DATE_ADDR] == month_last(regs[rtc_pkg::MONTH_ADDR], regs[rtc_pkg::YEAR_ADDR]);
      t = bcd_inc(regs[rtc_pkg::DATE_ADDR], 8'h31);
      next_regs[rtc_pkg::DATE_ADDR] = c ? rtc_pkg::CAL_ONE : t[7:0];
    end
    if (c) begin
      h = regs[rtc_pkg::MONTH_ADDR];
      c = h[4:0] == 5'h12;
      t = bcd_inc({3'b000, h[4:0]}, 8'h12);
      next_regs[rtc_pkg::MONTH_ADDR] = c ? {h[7], 7'h01} : {h[7], 2'b00, t[4:0]};
    end
    if (c) begin
      t = bcd_inc(regs[rtc_pkg::YEAR_ADDR], rtc_pkg::BCD_99);
      next_regs[rtc_pkg::YEAR_ADDR] = t[7:0];
      next_regs[rtc_pkg::MONTH_ADDR][7] = h[7] ^ t[8];
    end
    if (wr) begin
      if (wr_addr == rtc_pkg::DEVICE_STATUS_ADDR) begin
        next_regs[wr_addr] = (wdata & rtc_pkg::STATUS_WR_MASK) |
                             (wdata & regs[wr_addr] & rtc_pkg::STATUS_CLR_MASK);
      end else begin
        next_regs[wr_addr] = wdata;
      end
    end
    // Flag sets come last so that an event beats a clear in the same cycle.
    if (osf_set) begin
      next_regs[rtc_pkg::DEVICE_STATUS_ADDR][rtc_pkg::ST_OSC_STOPPED_FLAG] = 1'b1;
    end
    if (chk && fmatch(regs[rtc_pkg::A1_SEC_ADDR], regs[rtc_pkg::SEC_ADDR]) &&
        fmatch(regs[rtc_pkg::A1_MIN_ADDR], regs[rtc_pkg::MIN_ADDR]) &&
        fmatch(regs[rtc_pkg::A1_HOUR_ADDR], regs[rtc_pkg::HOUR_ADDR]) &&
        day_match(regs[rtc_pkg::A1_DAY_ADDR], regs[rtc_pkg::WDAY_ADDR], regs[rtc_pkg::DATE_ADDR])) begin
      next_regs[rtc_pkg::DEVICE_STATUS_ADDR][rtc_pkg::ST_A1_FLAG] = 1'b1;
    end
    if (chk && regs[rtc_pkg::SEC_ADDR] == 8'h00 &&
        fmatch(regs[rtc_pkg::A2_MIN_ADDR], regs[rtc_pkg::MIN_ADDR]) &&
        fmatch(regs[rtc_pkg::A2_HOUR_ADDR], regs[rtc_pkg::HOUR_ADDR]) &&
        day_match(regs[rtc_pkg::A2_DAY_ADDR], regs[rtc_pkg::WDAY_ADDR], regs[rtc_pkg::DATE_ADDR])) begin
      next_regs[rtc_pkg::DEVICE_STATUS_ADDR][rtc_pkg::ST_A2_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        regs[i] <= 8'h00;
      end
      regs[rtc_pkg::WDAY_ADDR] <= rtc_pkg::CAL_ONE;
      regs[rtc_pkg::DATE_ADDR] <= rtc_pkg::CAL_ONE;
      regs[rtc_pkg::MONTH_ADDR] <= rtc_pkg::CAL_ONE;
      regs[rtc_pkg::DEVICE_CONTROL_ADDR] <= rtc_pkg::CTL_RESET;
      regs[rtc_pkg::DEVICE_STATUS_ADDR] <= rtc_pkg::STATUS_RESET;
      chk <= 1'b0;
    end else begin
      regs <= next_regs;
      chk <= sec_s ^ sec_d;
    end
  end

  // Reset recovery, oscillator watchdog and pin drivers.
  always_comb begin
    next_rec_cnt = rec_cnt;
    next_rst_act = rst_act;
    if (!pwr_s) begin
      next_rst_act = 1'b1;
      next_rec_cnt = '0;
    end else if (rst_act) begin
      if (regs[rtc_pkg::DEVICE_CONTROL_ADDR][rtc_pkg::CTL_OSC_DISABLE_N]) begin
        next_rst_act = 1'b0;
      end else if (rec_cnt == RW'(REC_CYC - 1)) begin
        next_rst_act = 1'b0;
      end else begin
        next_rec_cnt = rec_cnt + RW'(1);
      end
    end
    // A heartbeat edge from the oscillator restarts the watchdog.
    next_osf_set = 1'b0;
    next_osf_cnt = osf_cnt;
    if (hb_s ^ hb_d) begin
      next_osf_cnt = '0;
    end else if (osf_cnt == OW'(OSF_CYC - 1)) begin
      next_osf_set = 1'b1;
    end else begin
      next_osf_cnt = osf_cnt + OW'(1);
    end
    next_ref_gate = regs[rtc_pkg::DEVICE_STATUS_ADDR][rtc_pkg::ST_REF_OUT_ENABLE] &
                    regs[rtc_pkg::DEVICE_STATUS_ADDR][rtc_pkg::ST_REF_OUT_BATTERY_ENABLE];
    if (regs[rtc_pkg::DEVICE_CONTROL_ADDR][rtc_pkg::CTL_IRQ_MODE_SELECT]) begin
      next_int_oe = (regs[rtc_pkg::DEVICE_STATUS_ADDR][rtc_pkg::ST_A1_FLAG] &
                     regs[rtc_pkg::DEVICE_CONTROL_ADDR][rtc_pkg::CTL_A1_ENABLE]) |
                    (regs[rtc_pkg::DEVICE_STATUS_ADDR][rtc_pkg::ST_A2_FLAG] &
                     regs[rtc_pkg::DEVICE_CONTROL_ADDR][rtc_pkg::CTL_A2_ENABLE]);
    end else begin
      next_int_oe = ~sqw_s;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rst_act <= 1'b1;
      rec_cnt <= '0;
      osf_set <= 1'b0;
      osf_cnt <= '0;
      ref_gate <= 1'b0;
      alarm_irq_sqwave_n_oe_o <= 1'b0;
      reset_n_oe_o <= 1'b1;
      pin_low <= 1'b0;
    end else begin
      rst_act <= next_rst_act;
      rec_cnt <= next_rec_cnt;
      osf_set <= next_osf_set;
      osf_cnt <= next_osf_cnt;
      ref_gate <= next_ref_gate;
      alarm_irq_sqwave_n_oe_o <= next_int_oe;
      reset_n_oe_o <= next_rst_act;
      pin_low <= 1'b0;
    end
  end
  // Open-drain pins only ever pull low; the enables carry the information.
  assign alarm_irq_sqwave_n_o = pin_low;
  assign reset_n_o = pin_low;
  assign sda_o = pin_low;
endmodule : rtc_core

// file: rtl/rtc_pkg.sv
// Shared constants of the real-time clock core: register map, field positions,
// reset values and timing figures.
// Assumes a 100 MHz system clock and an oscillator clock at twice the reference rate.
package rtc_pkg;
  // Register indices, one byte each.
  localparam logic [3:0] SEC_ADDR = 4'h0;
  localparam logic [3:0] MIN_ADDR = 4'h1;
  localparam logic [3:0] HOUR_ADDR = 4'h2;
  localparam logic [3:0] WDAY_ADDR = 4'h3;
  localparam logic [3:0] DATE_ADDR = 4'h4;
  localparam logic [3:0] MONTH_ADDR = 4'h5;
  localparam logic [3:0] YEAR_ADDR = 4'h6;
  localparam logic [3:0] A1_SEC_ADDR = 4'h7;
  localparam logic [3:0] A1_MIN_ADDR = 4'h8;
  localparam logic [3:0] A1_HOUR_ADDR = 4'h9;
  localparam logic [3:0] A1_DAY_ADDR = 4'ha;
  localparam logic [3:0] A2_MIN_ADDR = 4'hb;
  localparam logic [3:0] A2_HOUR_ADDR = 4'hc;
  localparam logic [3:0] A2_DAY_ADDR = 4'hd;
  localparam logic [3:0] DEVICE_CONTROL_ADDR = 4'he;
  localparam logic [3:0] DEVICE_STATUS_ADDR = 4'hf;
  // Field positions.
  localparam int CTL_OSC_DISABLE_N = 7;
  localparam int CTL_RATE_SELECT_HI = 4;
  localparam int CTL_RATE_SELECT_LO = 3;
  localparam int CTL_IRQ_MODE_SELECT = 2;
  localparam int CTL_A2_ENABLE = 1;
  localparam int CTL_A1_ENABLE = 0;
  localparam int ST_OSC_STOPPED_FLAG = 7;
  localparam int ST_REF_OUT_BATTERY_ENABLE = 6;
  localparam int ST_REF_OUT_ENABLE = 3;
  localparam int ST_A2_FLAG = 1;
  localparam int ST_A1_FLAG = 0;
  localparam int HOUR_12H = 6;
  localparam int HOUR_PM = 5;
  localparam int ALARM_MASK = 7;
  localparam int ALARM_BY_WDAY = 6;
  // Reset values and write masks.
  localparam logic [7:0] CTL_RESET = 8'h1c;
  localparam logic [7:0] STATUS_RESET = 8'hc8;
  localparam logic [7:0] STATUS_WR_MASK = 8'h48;
  localparam logic [7:0] STATUS_CLR_MASK = 8'h83;
  localparam logic [7:0] CAL_ONE = 8'h01;
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_23 = 8'h23;
  localparam logic [7:0] BCD_99 = 8'h99;
  // Oscillator divider taps.
  localparam int DIV_W = 16;
  localparam int TAP_8K = 2;
  localparam int TAP_4K = 3;
  localparam int TAP_1K = 5;
  localparam int TAP_HEART = 3;
  // Timing.
  localparam int SYS_HZ = 100_000_000;
  localparam int CYC_PER_MS = SYS_HZ / 1000;
  localparam int RECOVERY_MS = 125;
  localparam int RECOVERY_MAX_MS = 300;
  localparam int OSC_STOP_MS = 100;
  localparam int TIMEOUT_MS = 25;
  localparam int RECOVERY_CYC = RECOVERY_MS * CYC_PER_MS;
  localparam int OSC_STOP_CYC = OSC_STOP_MS * CYC_PER_MS;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * CYC_PER_MS;
endpackage : rtc_pkg

// file: rtl/i2c_target.sv
// Serial register port: byte-wide target with an auto-incrementing pointer.
// Assumes raw bus levels at its inputs; it synchronises them itself.
`timescale 1ns/10ps
module i2c_target #(
  parameter logic [6:0] DEV_ADDR = 7'h42,
  parameter int TO_CYC = rtc_pkg::TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_o,
  // Register side
  output logic wr_o,
  output logic [3:0] wr_addr_o,
  output logic [7:0] wdata_o,
  output logic [3:0] ptr_o,
  input wire logic [7:0] rdata_i
);
  localparam int TW = $clog2(TO_CYC + 1);
  typedef enum logic [5:0] {
    IDLE = 6'h01, ADDR = 6'h02, ACK = 6'h04, WRITE = 6'h08, READ = 6'h10, RACK = 6'h20
  } st_type;
  st_type st, next_st;
  logic [2:0] scl_q, sda_q;
  logic [3:0] bitc, next_bitc, next_ptr, next_wr_addr;
  logic [7:0] sh, next_sh, next_wdata;
  logic [TW-1:0] tcnt, next_tcnt;
  logic rw, next_rw, first, next_first, next_oe, next_wr;
  logic rise, fall, start, stop;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], scl_i};
      sda_q <= {sda_q[1:0], sda_i};
    end
  end
  assign rise = scl_q[1] & ~scl_q[2];
  assign fall = ~scl_q[1] & scl_q[2];
  assign start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  assign stop = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

  always_comb begin
    next_st = st;
    next_bitc = bitc;
    next_sh = sh;
    next_ptr = ptr_o;
    next_rw = rw;
    next_first = first;
    next_oe = sda_oe_o;
    next_wr = 1'b0;
    next_wr_addr = wr_addr_o;
    next_wdata = wdata_o;
    next_tcnt = (st == IDLE) ? '0 : tcnt + TW'(1);
    case (st)
      ADDR: begin
        if (rise) begin
          next_sh = {sh[6:0], sda_q[1]};
          next_bitc = bitc + 4'h1;
        end else if (fall && bitc == 4'h8) begin
          next_oe = (sh[7:1] == DEV_ADDR);
          next_st = (sh[7:1] == DEV_ADDR) ? ACK : IDLE;
          next_rw = sh[0];
          next_first = ~sh[0];
        end
      end
      ACK: begin
        if (fall) begin
          next_bitc = 4'h0;
          next_st = rw ? READ : WRITE;
          next_sh = rdata_i;
          next_oe = rw & ~rdata_i[7];
        end
      end
      WRITE: begin
        if (rise) begin
          next_sh = {sh[6:0], sda_q[1]};
          next_bitc = bitc + 4'h1;
        end else if (fall && bitc == 4'h8) begin
          next_first = 1'b0;
          next_oe = 1'b1;
          next_st = ACK;
          if (first) begin
            next_ptr = sh[3:0];
          end else begin
            next_wr = 1'b1;
            next_wr_addr = ptr_o;
            next_wdata = sh;
            next_ptr = ptr_o + 4'h1;
          end
        end
      end
      READ: begin
        if (rise) begin
          next_bitc = bitc + 4'h1;
        end else if (fall && bitc == 4'h8) begin
          next_oe = 1'b0;
          next_st = RACK;
          next_ptr = ptr_o + 4'h1;
        end else if (fall) begin
          next_sh = {sh[6:0], 1'b0};
          next_oe = ~sh[6];
        end
      end
      RACK: begin
        if (rise) begin
          next_st = sda_q[1] ? IDLE : RACK;
          next_bitc = 4'h9;
        end else if (fall && bitc == 4'h9) begin
          next_bitc = 4'h0;
          next_sh = rdata_i;
          next_oe = ~rdata_i[7];
          next_st = READ;
        end
      end
      default: next_st = IDLE;
    endcase
    if (start) begin
      next_st = ADDR;
      next_bitc = 4'h0;
      next_oe = 1'b0;
      next_tcnt = '0;
    end else if (stop || (st != IDLE && tcnt == TW'(TO_CYC - 1))) begin
      next_st = IDLE;
      next_oe = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= IDLE;
      bitc <= 4'h0;
      sh <= 8'h00;
      ptr_o <= 4'h0;
      rw <= 1'b0;
      first <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_o <= 1'b0;
      wr_addr_o <= 4'h0;
      wdata_o <= 8'h00;
      tcnt <= '0;
    end else begin
      st <= next_st;
      bitc <= next_bitc;
      sh <= next_sh;
      ptr_o <= next_ptr;
      rw <= next_rw;
      first <= next_first;
      sda_oe_o <= next_oe;
      wr_o <= next_wr;
      wr_addr_o <= next_wr_addr;
      wdata_o <= next_wdata;
      tcnt <= next_tcnt;
    end
  end
endmodule : i2c_target

// file: verification/rtc_core_props.sv
// Pin-level checker for the clock core.
// Assumes the pins are wired open-drain with pull-ups on the board side.
`timescale 1ns/10ps
module rtc_core_props #(
  parameter int REC_CYC = 200
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic osc_clk_i,
  input wire logic power_ok_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic alarm_irq_sqwave_n_o,
  input wire logic reset_n_oe_o,
  input wire logic ref_clock_out_o
);
  int hi_cnt;
  // Saturates so the release window is seen exactly once per supply-good run.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i)
      hi_cnt <= 0;
    else if (!power_ok_i)
      hi_cnt <= 0;
    else if (hi_cnt < REC_CYC + 20)
      hi_cnt <= hi_cnt + 1;
  end
  sequence s_supply_lost;
    !power_ok_i [*5];
  endsequence
  sequence s_scl_high;
    scl_i [*5];
  endsequence
  property p_pf_reset;
    @(posedge clock_i) disable iff (!rst_b_i) s_supply_lost |-> reset_n_oe_o;
  endproperty
  property p_rec_max;
    @(posedge clock_i) disable iff (!rst_b_i) (hi_cnt == REC_CYC + 16) |-> !reset_n_oe_o;
  endproperty
  property p_rec_min;
    @(posedge clock_i) disable iff (!rst_b_i) $fell(reset_n_oe_o) |-> $past(power_ok_i, 2) && $past(power_ok_i, 3);
  endproperty
  property p_ref_half;
    @(posedge osc_clk_i) disable iff (!rst_b_i) ref_clock_out_o |=> !ref_clock_out_o;
  endproperty
  property p_sda_od;
    @(posedge clock_i) disable iff (!rst_b_i) !sda_o;
  endproperty
  property p_pin_od;
    @(posedge clock_i) disable iff (!rst_b_i) !alarm_irq_sqwave_n_o;
  endproperty
  property p_ack_low;
    @(posedge clock_i) disable iff (!rst_b_i) $rose(sda_oe_o) |-> !scl_i && !$past(scl_i, 2);
  endproperty
  property p_scl_stable;
    @(posedge clock_i) disable iff (!rst_b_i) s_scl_high |-> $stable(sda_oe_o);
  endproperty
  a_pf_reset: assert property (p_pf_reset) else $error("reset pin free while supply low");
  a_rec_max: assert property (p_rec_max) else $error("reset pin held too long");
  a_rec_min: assert property (p_rec_min) else $error("reset pin freed without supply");
  a_ref_half: assert property (p_ref_half) else $error("reference output not half rate");
  a_sda_od: assert property (p_sda_od) else $error("data line driven high");
  a_pin_od: assert property (p_pin_od) else $error("alarm pin driven high");
  a_ack_low: assert property (p_ack_low) else $error("data pulled while clock high");
  a_scl_stable: assert property (p_scl_stable) else $error("data moved during clock high");
endmodule : rtc_core_props
bind rtc_core rtc_core_props #(.REC_CYC(REC_CYC)) rtc_core_props_inst (.clock_i(clock_i), .rst_b_i(rst_b_i),
  .osc_clk_i(osc_clk_i), .power_ok_i(power_ok_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .alarm_irq_sqwave_n_o(alarm_irq_sqwave_n_o), .reset_n_oe_o(reset_n_oe_o), .ref_clock_out_o(ref_clock_out_o));

// file: verification/i2c_host.sv
// Serial bus master model, bit-banged at a slow fixed rate.
// Assumes the data wire is pulled up and resolved by the bench.
`timescale 1ns/10ps
module i2c_host (
  input wire logic clock_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge clock_i);
  endtask : wait_n
  task automatic start();
    sda_pull_o = 1'b0;
    wait_n(10);
    scl_o = 1'b1;
    wait_n(10);
    sda_pull_o = 1'b1;
    wait_n(10);
    scl_o = 1'b0;
    wait_n(2);
  endtask : start
  task automatic stop();
    sda_pull_o = 1'b1;
    wait_n(10);
    scl_o = 1'b1;
    wait_n(10);
    sda_pull_o = 1'b0;
    wait_n(10);
  endtask : stop
  // Sends nb bits MSB first from d[8], sampling the wire into q.
  task automatic xfer(input logic [8:0] d, input int nb, output logic [8:0] q);
    q = '0;
    for (int k = 0; k < nb; k++) begin
      sda_pull_o = ~d[8 - k];
      wait_n(10);
      scl_o = 1'b1;
      wait_n(5);
      q[8 - k] = sda_i;
      wait_n(5);
      scl_o = 1'b0;
      wait_n(2);
    end
  endtask : xfer
endmodule : i2c_host

// file: verification/tb.sv
// Self-checking bench for the clock core, driving the serial bus as master.
// Assumes shortened recovery, stop-detect and timeout counts.
`timescale 1ns/10ps
module tb;
  localparam int REC = 200;
  localparam int TO = 3000;
  logic clock_i, rst_b_i, osc_clk, osc_run, power_ok, scl, pull, sda_oe, irq_oe, rst_oe, ref_out, sda_w;
  int fails, compares, n, ref_hi, irq_tg, irq_hi;
  int divs[4] = '{65536, 64, 16, 8};
  logic [8:0] r9;
  assign sda_w = ~(pull | sda_oe);
  i2c_host i2c_host_inst (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl), .sda_pull_o(pull));
  rtc_core #(.REC_CYC(REC), .OSF_CYC(2000), .TO_CYC(TO)) rtc_core_inst (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .osc_clk_i(osc_clk), .power_ok_i(power_ok), .scl_i(scl), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe),
    .alarm_irq_sqwave_n_i(~irq_oe), .alarm_irq_sqwave_n_o(), .alarm_irq_sqwave_n_oe_o(irq_oe),
    .reset_n_i(~rst_oe), .reset_n_o(), .reset_n_oe_o(rst_oe), .ref_clock_out_o(ref_out));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // The oscillator stands still while osc_run is low.
  initial begin
    osc_clk = 1'b0;
    forever #24 osc_clk = osc_run & ~osc_clk;
  end
  task automatic results();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(negedge clock_i);
  endtask : cyc
  task automatic send(input logic [3:0] a);
    i2c_host_inst.start();
    i2c_host_inst.xfer(9'h109, 9, r9);
    check({7'h00, r9[0]}, 8'h00);
    i2c_host_inst.xfer({4'h0, a, 1'b1}, 9, r9);
  endtask : send
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    send(a);
    i2c_host_inst.xfer({d, 1'b1}, 9, r9);
    check({7'h00, r9[0]}, 8'h00);
    i2c_host_inst.stop();
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    send(a);
    i2c_host_inst.start();
    i2c_host_inst.xfer(9'h10b, 9, r9);
    i2c_host_inst.xfer(9'h1ff, 9, r9);
    check(r9[8:1], e);
    i2c_host_inst.stop();
  endtask : rd
  task automatic watch(input int k);
    logic last;
    ref_hi = 0;
    irq_tg = 0;
    irq_hi = 0;
    last = irq_oe;
    repeat (k) begin
      @(negedge clock_i);
      ref_hi += ref_out;
      irq_hi += irq_oe;
      irq_tg += (irq_oe != last);
      last = irq_oe;
    end
  endtask : watch
  task automatic wait_rel(input int lim);
    n = 0;
    while (rst_oe !== 1'b0) begin
      cyc(1);
      n++;
      if (n > lim) begin
        fails++;
        results();
      end
    end
  endtask : wait_rel
  initial begin
    rst_b_i = 1'b0;
    power_ok = 1'b0;
    osc_run = 1'b1;
    cyc(3);
    rst_b_i = 1'b1;
    cyc(20);
    check({7'h00, rst_oe}, 8'h01);
    power_ok = 1'b1;
    wait_rel(REC + 100);
    check({7'h00, n >= REC}, 8'h01);
    rd(rtc_pkg::DEVICE_CONTROL_ADDR, rtc_pkg::CTL_RESET);
    rd(rtc_pkg::DEVICE_STATUS_ADDR, rtc_pkg::STATUS_RESET);
    watch(400);
    check(8'(irq_hi), 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(rtc_pkg::DEVICE_CONTROL_ADDR, {3'h0, i[1:0], 3'h0});
      watch(800);
      n = 16000 / (divs[i] * 48);
      check({7'h00, irq_tg >= n - 2 && irq_tg <= n + 2}, 8'h01);
    end
    wr(rtc_pkg::DEVICE_CONTROL_ADDR, rtc_pkg::CTL_RESET);
    watch(400);
    check(8'(irq_hi), 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(rtc_pkg::DEVICE_STATUS_ADDR, {1'b0, i[1], 2'h0, i[0], 3'h0});
      watch(200);
      check({7'h00, i == 3 ? (ref_hi > 80 && ref_hi < 120) : ref_hi == 0}, 8'h01);
    end
    rd(rtc_pkg::DEVICE_STATUS_ADDR, 8'h48);
    osc_run = 1'b0;
    cyc(1000);
    osc_run = 1'b1;
    rd(rtc_pkg::DEVICE_STATUS_ADDR, 8'h48);
    osc_run = 1'b0;
    cyc(2500);
    osc_run = 1'b1;
    rd(rtc_pkg::DEVICE_STATUS_ADDR, 8'hc8);
    rd(rtc_pkg::DEVICE_STATUS_ADDR, 8'hc8);
    wr(rtc_pkg::DEVICE_STATUS_ADDR, 8'h48);
    rd(rtc_pkg::DEVICE_STATUS_ADDR, 8'h48);
    i2c_host_inst.start();
    i2c_host_inst.xfer(9'h109, 8, r9);
    cyc(8);
    check({7'h00, sda_oe}, 8'h01);
    cyc(TO);
    check({7'h00, sda_oe}, 8'h00);
    i2c_host_inst.stop();
    rd(rtc_pkg::DEVICE_STATUS_ADDR, 8'h48);
    for (int i = 0; i < 2; i++) begin
      wr(rtc_pkg::DEVICE_CONTROL_ADDR, {i[0], 7'h1c});
      power_ok = 1'b0;
      cyc(10);
      check({7'h00, rst_oe}, 8'h01);
      power_ok = 1'b1;
      wait_rel(REC + 100);
      check({7'h00, n < 10}, {7'h00, i[0]});
    end
    results();
  end
endmodule : tb
